// [scd_pkg.sv]
// Constants, types and arithmetic helpers for the sensor compensation datapath
// Operation
// - Four-bit field chooses the temperature source, internal sensor or external pins.
// - Two-bit field sets the temperature amplifier gain code.
// - One bit picks single-ended (ground referenced) or differential temperature input.
// - Each temperature result is readable as separate high and low bytes.
// - Temperature modulator runs at 1 MHz giving a 3-bit stream to the decimator.
// - Temperature decimator delivers one new sample every 128 us.
// - Decimator output is 16-bit two's complement, 0x8000 to 0x7fff.
// - Internal sensor at gain five: code is 25.9 per degree plus 6680.
// - Output converter takes a 14-bit code, absolute or supply ratiometric.
// - Any reset forces the output converter code to zero.
// - Capacitor enable bit closes or opens the external filter capacitor switch.
// - Ratiometric bit selects supply ratiometric or supply independent output.
// - Three-bit output gain applies in voltage mode; current mode uses fixed gain.
// - Compensated value is gain coefficient times the sum of sample and offset, 16-bit coefficients.
// - Output is four cubics in temperature weighted by pressure powers zero to three.
// - Polynomial uses sixteen stored coefficients, four per pressure power.
// - Corrected word passes a second-order recursive filter before the converter.
// - Filter intermediate from a0, a1, a2; output is b-weighted sum of intermediates.
// - Filter coefficient a0 equal to zero disables filtering.
// - Values beyond normal thresholds are replaced by high or low clamp values.
package scd_pkg;
	localparam int CLK_PERIOD_NS    = 4;
	localparam int MOD_PERIOD_NS    = 1000;
	localparam int MOD_DIV          = MOD_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_PERIOD_US = 128;
	localparam int SAMPLE_TICKS     = SAMPLE_PERIOD_US * 1000 / MOD_PERIOD_NS;
	localparam int DEC_SHIFT        = 6;
	// Nominal internal sensor relation, not used by any module or model
	localparam int TEMP_SLOPE_X10   = 259;
	localparam int TEMP_OFFSET_CODE = 6680;

	localparam logic [7:0] ADDR_TEMP_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_TEMP_GAIN  = 8'h04;
	localparam logic [7:0] ADDR_SINGLE_ENDED_SELECT    = 8'h08;
	localparam logic [7:0] ADDR_TRES_HIGH  = 8'h0c;
	localparam logic [7:0] ADDR_TRES_LOW   = 8'h10;
	localparam logic [7:0] ADDR_OUT_STAGE  = 8'h14;
	localparam logic [7:0] ADDR_DAC_CONFIG = 8'h18;
	localparam logic [7:0] ADDR_P_GAIN     = 8'h1c;
	localparam logic [7:0] ADDR_P_OFFSET   = 8'h20;
	localparam logic [7:0] ADDR_T_GAIN     = 8'h24;
	localparam logic [7:0] ADDR_T_OFFSET   = 8'h28;
	localparam logic [7:0] ADDR_DAC_CODE   = 8'h2c;
	localparam int         COEF_WIN_BIT    = 7;

	localparam int OS_CAP_BIT  = 0;
	localparam int OS_GAIN_LSB = 1;
	localparam int OS_CUR_BIT  = 4;

	localparam logic [4:0] COEF_H0     = 5'h00;
	localparam logic [4:0] COEF_M3     = 5'h0f;
	localparam logic [4:0] COEF_A0     = 5'h10;
	localparam logic [4:0] COEF_A1     = 5'h11;
	localparam logic [4:0] COEF_A2     = 5'h12;
	localparam logic [4:0] COEF_B0     = 5'h13;
	localparam logic [4:0] COEF_B1     = 5'h14;
	localparam logic [4:0] COEF_B2     = 5'h15;
	localparam logic [4:0] COEF_NLOW   = 5'h16;
	localparam logic [4:0] COEF_NHIGH  = 5'h17;
	localparam logic [4:0] COEF_LCLAMP = 5'h18;
	localparam logic [4:0] COEF_HCLAMP = 5'h19;
	localparam int         COEF_DEPTH  = 32;

	localparam int T_FRAC   = 15;
	localparam int P_FRAC   = 14;
	localparam int DG_FRAC  = 14;
	localparam int IIR_FRAC = 14;
	localparam int H_SHIFT  = 2;

	localparam logic [15:0] DGAIN_RST  = 16'h4000;
	localparam logic [15:0] DOFS_RST   = 16'h0000;
	localparam logic [13:0] DAC_RST    = 14'h0000;
	localparam logic [13:0] DAC_MAX    = 14'h3fff;
	localparam logic [2:0]  GAIN_FIXED = 3'h0;

	typedef enum logic [2:0] {ST_IDLE, ST_GAIN, ST_RD, ST_POLY, ST_IIR, ST_CLAMP, ST_OUT}
		scd_fsm_t;

	typedef struct packed {
		logic [3:0]         temp_source;
		logic [1:0]         temp_gain;
		logic               single_ended;
		logic               cap_connect;
		logic [2:0]         dac_gain;
		logic               current_mode;
		logic               ratiometric;
		logic signed [15:0] p_gain;
		logic signed [15:0] p_ofs;
		logic signed [15:0] t_gain;
		logic signed [15:0] t_ofs;
	} scd_cfg_t;

	// Fixed point multiply with saturation, so no product ever wraps
	function automatic logic signed [31:0] scd_fmul(input logic signed [31:0] a,
			input logic signed [15:0] b, input int sh);
		logic signed [47:0] p;
		p = (a * b) >>> sh;
		if (p > 48'sh0000_7fff_ffff) return 32'sh7fff_ffff;
		else if (p < -48'sh0000_8000_0000) return 32'sh8000_0000;
		else return p[31:0];
	endfunction

	function automatic logic signed [15:0] scd_sat16(input logic signed [39:0] v);
		if (v > 40'sh00_0000_7fff) return 16'sh7fff;
		else if (v < -40'sh00_0000_8000) return 16'sh8000;
		else return v[15:0];
	endfunction
endpackage

// [scd_coef_mem.sv]
// Coefficient store with registered read port
module scd_coef_mem
	import scd_pkg::*;
#(
	parameter int W  = 16,
	parameter int D  = COEF_DEPTH,
	parameter int AW = $clog2(D)
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] widx,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] ridx,
	output logic      [W-1:0]  rdata
);
	if (D < 26 || W < 16) begin : g_bad
		$error("scd_coef_mem: too small for the coefficient set");
	end

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [W-1:0]        rd;
	} scd_mem_t;

	scd_mem_t st;
	scd_mem_t next_st;

	always_comb begin
		next_st = st;
		next_st.rd = st.mem[ridx];
		if (we) begin
			next_st.mem[widx] = wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rd;
endmodule // scd_coef_mem

// [scd_temp_decim.sv]
// Temperature modulator pacing and decimation to 16-bit samples
module scd_temp_decim
	import scd_pkg::*;
#(
	parameter int DIV   = MOD_DIV,
	parameter int TICKS = SAMPLE_TICKS
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [2:0]  mod_stream,
	output logic             mod_strobe,
	output logic [15:0]      sample,
	output logic             sample_valid
);
	if (DIV < 2 || TICKS < 2 || TICKS > 256) begin : g_bad
		$error("scd_temp_decim: divider or decimation count out of range");
	end

	typedef struct packed {
		logic [2:0]         s1;
		logic [2:0]         s2;
		logic [15:0]        div;
		logic               tick;
		logic [8:0]         cnt;
		logic signed [15:0] sum;
		logic [15:0]        data;
		logic               valid;
	} scd_dec_t;

	scd_dec_t st;
	scd_dec_t next_st;

	always_comb begin
		logic signed [15:0] acc;
		acc = '0;
		next_st = st;
		next_st.s1 = mod_stream;
		next_st.s2 = st.s1;
		next_st.tick = 1'b0;
		next_st.valid = 1'b0;
		if (st.div == 16'(DIV - 1)) begin
			next_st.div = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.div = st.div + 16'h0001;
		end
		if (st.tick) begin
			acc = st.sum + 16'(signed'(st.s2));
			if (st.cnt == 9'(TICKS - 1)) begin
				next_st.data = scd_sat16(40'(acc) <<< DEC_SHIFT);
				next_st.valid = 1'b1;
				next_st.sum = '0;
				next_st.cnt = '0;
			end else begin
				next_st.sum = acc;
				next_st.cnt = st.cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign mod_strobe = st.tick;
	assign sample = st.data;
	assign sample_valid = st.valid;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_tick_spacing: assert property (
		mod_strobe |=> (!mod_strobe) [*8])
		else $error("modulator strobe repeats too soon");
	a_sample_on_tick: assert property (
		sample_valid |-> $past(mod_strobe) ##1 (!sample_valid) [*8])
		else $error("sample not aligned to modulator strobe");
endmodule // scd_temp_decim

// [scd_datapath.sv]
// Compensation datapath top: AHB-Lite registers, polynomial, filter and clamp
module scd_datapath
	import scd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [2:0]  mod_stream,
	input  wire logic [15:0] pressure_sample,
	output logic             mod_strobe,
	output logic      [3:0]  temp_source_select,
	output logic      [1:0]  temp_gain_code,
	output logic             single_ended_select,
	output logic             filter_cap_connect,
	output logic      [2:0]  dac_gain_code,
	output logic             dac_current_mode,
	output logic             dac_ratiometric,
	output logic      [13:0] dac_code,
	output logic             dac_strobe
);
	typedef struct packed {
		scd_cfg_t           cfg;
		logic [2:0]         gain_out;
		scd_fsm_t           fsm;
		logic [31:0]        rdata;
		logic               rdy;
		logic               wr_pend;
		logic [7:0]         wr_addr;
		logic [15:0]        tres;
		logic signed [15:0] padc;
		logic signed [15:0] tadc;
		logic signed [15:0] p;
		logic signed [15:0] t;
		logic [4:0]         addr;
		logic signed [31:0] acc_t;
		logic signed [31:0] acc_p;
		logic signed [39:0] acc_i;
		logic               bypass;
		logic signed [15:0] x;
		logic signed [15:0] w;
		logic signed [15:0] w1;
		logic signed [15:0] w2;
		logic signed [15:0] y;
		logic signed [15:0] yc;
		logic signed [15:0] nlow;
		logic signed [15:0] nhigh;
		logic [13:0]        dac;
		logic               dac_stb;
	} scd_dp_t;

	scd_dp_t     st;
	scd_dp_t     next_st;
	logic        mem_we;
	logic [4:0]  mem_widx;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic [15:0] dec_sample;
	logic        dec_valid;

	scd_temp_decim u_decim (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.mod_stream   (mod_stream),
		.mod_strobe   (mod_strobe),
		.sample       (dec_sample),
		.sample_valid (dec_valid)
	);

	// Coefficients live here, written by software as the nonvolatile image
	scd_coef_mem u_coef (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (mem_we),
		.widx    (mem_widx),
		.wdata   (mem_wdata),
		.ridx    (st.addr),
		.rdata   (mem_rdata)
	);

	always_comb begin
		logic signed [15:0] c;
		logic signed [15:0] op;
		logic signed [31:0] at;
		logic signed [31:0] comb;
		logic signed [39:0] acc;
		logic [31:0]        rd;
		c = signed'(mem_rdata);
		op = '0;
		at = '0;
		comb = '0;
		acc = '0;
		rd = '0;
		next_st = st;
		next_st.dac_stb = 1'b0;
		mem_we = 1'b0;
		mem_widx = '0;
		mem_wdata = '0;

		// Data phase of a write
		if (st.wr_pend) begin
			if (st.wr_addr == ADDR_TEMP_CTRL) begin
				next_st.cfg.temp_source = hwdata[3:0];
			end else if (st.wr_addr == ADDR_TEMP_GAIN) begin
				next_st.cfg.temp_gain = hwdata[1:0];
			end else if (st.wr_addr == ADDR_SINGLE_ENDED_SELECT) begin
				next_st.cfg.single_ended = hwdata[0];
			end else if (st.wr_addr == ADDR_OUT_STAGE) begin
				next_st.cfg.cap_connect = hwdata[OS_CAP_BIT];
				next_st.cfg.dac_gain = hwdata[OS_GAIN_LSB +: 3];
				next_st.cfg.current_mode = hwdata[OS_CUR_BIT];
			end else if (st.wr_addr == ADDR_DAC_CONFIG) begin
				next_st.cfg.ratiometric = hwdata[0];
			end else if (st.wr_addr == ADDR_P_GAIN) begin
				next_st.cfg.p_gain = hwdata[15:0];
			end else if (st.wr_addr == ADDR_P_OFFSET) begin
				next_st.cfg.p_ofs = hwdata[15:0];
			end else if (st.wr_addr == ADDR_T_GAIN) begin
				next_st.cfg.t_gain = hwdata[15:0];
			end else if (st.wr_addr == ADDR_T_OFFSET) begin
				next_st.cfg.t_ofs = hwdata[15:0];
			end else if (st.wr_addr[COEF_WIN_BIT]) begin
				mem_we = 1'b1;
				mem_widx = st.wr_addr[6:2];
				mem_wdata = hwdata[15:0];
			end
		end
		// Current mode pins the output gain regardless of the field
		next_st.gain_out = next_st.cfg.current_mode ? GAIN_FIXED
			: next_st.cfg.dac_gain;

		// Address phase; zero wait states, read data registered here
		next_st.wr_pend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			if (haddr[31:8] == 24'h000000) begin
				if (haddr[7:0] == ADDR_TEMP_CTRL) begin
					rd = {28'h0, st.cfg.temp_source};
				end else if (haddr[7:0] == ADDR_TEMP_GAIN) begin
					rd = {30'h0, st.cfg.temp_gain};
				end else if (haddr[7:0] == ADDR_SINGLE_ENDED_SELECT) begin
					rd = {31'h0, st.cfg.single_ended};
				end else if (haddr[7:0] == ADDR_TRES_HIGH) begin
					rd = {24'h0, st.tres[15:8]};
				end else if (haddr[7:0] == ADDR_TRES_LOW) begin
					rd = {24'h0, st.tres[7:0]};
				end else if (haddr[7:0] == ADDR_OUT_STAGE) begin
					rd = {27'h0, st.cfg.current_mode, st.cfg.dac_gain, st.cfg.cap_connect};
				end else if (haddr[7:0] == ADDR_DAC_CONFIG) begin
					rd = {31'h0, st.cfg.ratiometric};
				end else if (haddr[7:0] == ADDR_P_GAIN) begin
					rd = {16'h0, st.cfg.p_gain};
				end else if (haddr[7:0] == ADDR_P_OFFSET) begin
					rd = {16'h0, st.cfg.p_ofs};
				end else if (haddr[7:0] == ADDR_T_GAIN) begin
					rd = {16'h0, st.cfg.t_gain};
				end else if (haddr[7:0] == ADDR_T_OFFSET) begin
					rd = {16'h0, st.cfg.t_ofs};
				end else if (haddr[7:0] == ADDR_DAC_CODE) begin
					rd = {st.fsm != ST_IDLE, 17'h0, st.dac};
				end
				next_st.wr_pend = hwrite;
			end
			next_st.wr_addr = haddr[7:0];
			next_st.rdata = hwrite ? 32'h0 : rd;
		end

		// New converter sample starts one full update
		if (dec_valid) begin
			next_st.tres = dec_sample;
			next_st.tadc = signed'(dec_sample);
			next_st.padc = signed'(pressure_sample);
		end

		case (st.fsm)
			ST_IDLE: begin
				// A sample landing mid-update only refreshes the result registers
				if (dec_valid) begin
					next_st.fsm = ST_GAIN;
				end
			end
			ST_GAIN: begin
				next_st.p = scd_sat16(40'(scd_fmul(32'(st.padc) + 32'(st.cfg.p_ofs),
					st.cfg.p_gain, DG_FRAC)));
				next_st.t = scd_sat16(40'(scd_fmul(32'(st.tadc) + 32'(st.cfg.t_ofs),
					st.cfg.t_gain, DG_FRAC)));
				next_st.acc_t = '0;
				next_st.acc_p = '0;
				next_st.addr = COEF_M3;
				next_st.fsm = ST_RD;
			end
			ST_RD: begin
				if (st.addr <= COEF_M3) begin
					next_st.fsm = ST_POLY;
				end else if (st.addr <= COEF_B2) begin
					next_st.fsm = ST_IIR;
				end else begin
					next_st.fsm = ST_CLAMP;
				end
			end
			ST_POLY: begin
				// Horner in T inside a group, then in P across groups
				at = scd_fmul(st.acc_t, st.t, T_FRAC) + 32'(c);
				next_st.acc_t = at;
				next_st.fsm = ST_RD;
				next_st.addr = st.addr - 5'h01;
				if (st.addr[1:0] == 2'b00) begin
					comb = scd_fmul(st.acc_p, st.p, P_FRAC)
						+ ((st.addr == COEF_H0) ? (at <<< H_SHIFT) : at);
					next_st.acc_p = comb;
					next_st.acc_t = '0;
					if (st.addr == COEF_H0) begin
						next_st.x = scd_sat16(40'(comb));
						next_st.acc_i = '0;
						next_st.addr = COEF_A0;
					end
				end
			end
			ST_IIR: begin
				if (st.addr == COEF_A0 || st.addr == COEF_B0) begin
					op = (st.addr == COEF_A0) ? st.x : st.w;
				end else if (st.addr == COEF_A1 || st.addr == COEF_B1) begin
					op = st.w1;
				end else begin
					op = st.w2;
				end
				acc = st.acc_i + 40'(c) * 40'(op);
				next_st.acc_i = acc;
				next_st.addr = st.addr + 5'h01;
				next_st.fsm = ST_RD;
				if (st.addr == COEF_A0) begin
					next_st.bypass = (c == 16'sh0000);
				end
				if (st.addr == COEF_A2) begin
					next_st.w = scd_sat16(acc >>> IIR_FRAC);
					next_st.acc_i = '0;
				end
				if (st.addr == COEF_B2) begin
					next_st.y = st.bypass ? st.x : scd_sat16(acc >>> IIR_FRAC);
					next_st.w2 = st.w1;
					next_st.w1 = st.w;
				end
			end
			ST_CLAMP: begin
				next_st.addr = st.addr + 5'h01;
				next_st.fsm = ST_RD;
				if (st.addr == COEF_NLOW) begin
					next_st.nlow = c;
				end else if (st.addr == COEF_NHIGH) begin
					next_st.nhigh = c;
				end else if (st.addr == COEF_LCLAMP) begin
					next_st.yc = (st.y < st.nlow) ? c : st.y;
				end else begin
					if (st.y > st.nhigh) begin
						next_st.yc = c;
					end
					next_st.fsm = ST_OUT;
				end
			end
			ST_OUT: begin
				// Negative or oversize words pin to the converter limits
				if (st.yc < 16'sh0000) begin
					next_st.dac = '0;
				end else if (st.yc > signed'({2'b00, DAC_MAX})) begin
					next_st.dac = DAC_MAX;
				end else begin
					next_st.dac = st.yc[13:0];
				end
				next_st.dac_stb = 1'b1;
				next_st.fsm = ST_IDLE;
			end
			default: begin
				next_st.fsm = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.rdy <= 1'b1;
			st.fsm <= ST_IDLE;
			st.cfg.p_gain <= DGAIN_RST;
			st.cfg.t_gain <= DGAIN_RST;
			st.cfg.p_ofs <= DOFS_RST;
			st.cfg.t_ofs <= DOFS_RST;
			st.dac <= DAC_RST;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.rdata;
	assign hreadyout = st.rdy;
	assign hresp = 1'b0;
	assign temp_source_select = st.cfg.temp_source;
	assign temp_gain_code = st.cfg.temp_gain;
	assign single_ended_select = st.cfg.single_ended;
	assign filter_cap_connect = st.cfg.cap_connect;
	assign dac_gain_code = st.gain_out;
	assign dac_current_mode = st.cfg.current_mode;
	assign dac_ratiometric = st.cfg.ratiometric;
	assign dac_code = st.dac;
	assign dac_strobe = st.dac_stb;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_wr(logic [7:0] a);
		st.wr_pend && st.wr_addr == a;
	endsequence
	sequence s_start;
		dec_valid && st.fsm == ST_IDLE;
	endsequence

	a_src_write: assert property (
		s_wr(ADDR_TEMP_CTRL) |=> temp_source_select == $past(hwdata[3:0]))
		else $error("temperature source not taken from write");
	a_gain_write: assert property (
		s_wr(ADDR_TEMP_GAIN) |=> temp_gain_code == $past(hwdata[1:0]))
		else $error("temperature gain not taken from write");
	a_se_write: assert property (
		s_wr(ADDR_SINGLE_ENDED_SELECT) |=> single_ended_select == $past(hwdata[0]))
		else $error("single-ended select not taken from write");
	a_cap_write: assert property (
		s_wr(ADDR_OUT_STAGE) |=> filter_cap_connect == $past(hwdata[OS_CAP_BIT]))
		else $error("capacitor switch not taken from write");
	a_ratio_write: assert property (
		s_wr(ADDR_DAC_CONFIG) |=> dac_ratiometric == $past(hwdata[0]))
		else $error("ratiometric select not taken from write");
	a_gain_fixed: assert property (
		dac_current_mode |-> dac_gain_code == GAIN_FIXED)
		else $error("output gain not fixed in current mode");
	a_result_split: assert property (
		dec_valid |=> st.tres == $past(dec_sample))
		else $error("temperature result not captured");
	a_one_update: assert property (
		s_start |-> ##[2:200] dac_strobe)
		else $error("no output code for a sample");
	a_iir_bypass: assert property (
		(st.fsm == ST_IIR && st.addr == COEF_B2 && st.bypass) |=> st.y == $past(st.x))
		else $error("filter not bypassed with a0 zero");
	a_clamp_high: assert property (
		(st.fsm == ST_CLAMP && st.addr == COEF_HCLAMP && st.y > st.nhigh)
		|=> st.yc == $past(signed'(mem_rdata)))
		else $error("high clamp not applied");
	a_sat_low: assert property (
		(st.fsm == ST_OUT && st.yc < 16'sh0000) |=> dac_code == 14'h0000 && dac_strobe)
		else $error("negative result not saturated to zero");
endmodule // scd_datapath

// [scd_front_model.sv]
// Behavioural sensor front end: modulator codes and pressure words
module scd_front_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [2:0]  level,
	input  wire logic [15:0] pressure,
	output logic      [2:0]  mod_stream,
	output logic      [15:0] pressure_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_stream <= 3'h0;
			pressure_sample <= 16'h0000;
		end else begin
			mod_stream <= level;
			pressure_sample <= pressure;
		end
	end
endmodule // scd_front_model

// [test_sensor_compensation_datapath.sv]
// Self-checking bench for the compensation datapath
module test_sensor_compensation_datapath;
	timeunit 1ns;
	timeprecision 1ps;
	import scd_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, hresp, mod_strobe, single_ended_select;
	logic        filter_cap_connect, dac_current_mode, dac_ratiometric, dac_strobe;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans, temp_gain_code;
	logic [2:0]  hsize, level, mod_stream, dac_gain_code;
	logic [3:0]  temp_source_select;
	logic [15:0] pressure, pressure_sample;
	logic [13:0] dac_code;
	int          errors, check_count;
	time         t1;
	scd_front_model fe (.hclk(hclk), .hresetn(hresetn), .level(level), .pressure(pressure),
		.mod_stream(mod_stream), .pressure_sample(pressure_sample));
	scd_datapath dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .mod_stream(mod_stream),
		.pressure_sample(pressure_sample), .mod_strobe(mod_strobe),
		.temp_source_select(temp_source_select), .temp_gain_code(temp_gain_code),
		.single_ended_select(single_ended_select), .filter_cap_connect(filter_cap_connect),
		.dac_gain_code(dac_gain_code), .dac_current_mode(dac_current_mode),
		.dac_ratiometric(dac_ratiometric), .dac_code(dac_code), .dac_strobe(dac_strobe));
	always #2 hclk = ~hclk;
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for a signal seen high at a rising edge
	task automatic wait_high(ref logic s, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (s !== 1'b1 && n < lim);
		if (s !== 1'b1) begin
			errors++;
			summarize();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_high(hready, 100);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_high(hready, 100);
		r = hrdata;
	endtask
	// Write then let the register's update land
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		@(posedge hclk);
	endtask
	task automatic t_config();
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_TEMP_CTRL, i);
			check(temp_source_select, i);
		end
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_TEMP_GAIN, i);
			check(temp_gain_code, i);
		end
		for (int i = 1; i >= 0; i--) begin
			wr(ADDR_SINGLE_ENDED_SELECT, i);
			wr(ADDR_DAC_CONFIG, i);
			check({single_ended_select, dac_ratiometric}, {2{i[0]}});
		end
		wr(ADDR_OUT_STAGE, 32'h0000_000b);
		check({dac_current_mode, dac_gain_code, filter_cap_connect}, 5'h0b);
		wr(ADDR_OUT_STAGE, 32'h0000_001a);
		check({dac_current_mode, dac_gain_code, filter_cap_connect}, 5'h10);
		// Internal sensor wants single-ended input
		wr(ADDR_TEMP_CTRL, 32'h0000_0000);
		wr(ADDR_SINGLE_ENDED_SELECT, 32'h0000_0001);
		bus(1'b0, 32'h0000_0040, 32'h0);
		check(r, 32'h0);
		$display("config test done");
	endtask
	task automatic t_comp();
		wait_high(mod_strobe, 300);
		t1 = $time;
		@(posedge hclk);
		wait_high(mod_strobe, 300);
		check(($time - t1) / CLK_PERIOD_NS, MOD_DIV);
		// Pass-through setup: 4*h0 + P*g0/2^14 = 400 + 4096/2
		wr(32'h80 + 4 * COEF_H0, 32'd100);
		wr(32'h90, 32'h0000_2000);
		wr(32'h80 + 4 * COEF_NHIGH, 32'h0000_3fff);
		wait_high(dac_strobe, 40000);
		t1 = $time;
		check(dac_code, 14'h0990);
		bus(1'b0, ADDR_TRES_HIGH, 32'h0);
		check(r, 32'h20);
		bus(1'b0, ADDR_TRES_LOW, 32'h0);
		check(r, 32'h00);
		bus(1'b0, ADDR_DAC_CODE, 32'h0);
		check(r, 32'h0990);
		// Same gains and inputs on every sample
		// Filter on, y = x/2 = (-4096 + 2048)/2, below zero
		wr(32'h80 + 4 * COEF_H0, 32'h0000_fc00);
		wr(32'h80 + 4 * COEF_A0, 32'h0000_4000);
		wr(32'h80 + 4 * COEF_B0, 32'h0000_2000);
		wr(32'h80 + 4 * COEF_NLOW, 32'h0000_8000);
		wait_high(dac_strobe, 40000);
		check(($time - t1) / CLK_PERIOD_NS, SAMPLE_TICKS * MOD_DIV);
		check(dac_code, 14'h0000);
		t1 = $time;
		// y = 2448/2 is above normal high, so the high clamp wins
		wr(32'h80 + 4 * COEF_H0, 32'd100);
		wr(32'h80 + 4 * COEF_NHIGH, 32'd1000);
		wr(32'h80 + 4 * COEF_HCLAMP, 32'h0000_1234);
		@(posedge hclk);
		wait_high(dac_strobe, 40000);
		check(($time - t1) / CLK_PERIOD_NS, SAMPLE_TICKS * MOD_DIV);
		check(dac_code, 14'h1234);
		$display("compensation test done");
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		level = 3'h1;
		pressure = 16'h1000;
		errors = 0;
		check_count = 0;
		repeat (16) @(posedge hclk);
		check({dac_code, hready, hresp}, 16'h0002);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_config();
		t_comp();
		hresetn <= 1'b0;
		#1;
		check(dac_code, 14'h0000);
		$display("reset test done");
		summarize();
	end
endmodule // test_sensor_compensation_datapath
